// >>> core/lmfbi_ctrl.sv
// led matrix control: serial registers, font ram, blink, scan, brightness
//
// Summary of operation
// - blink output high in plane a
// - blink phase readable in configuration bit
// - font read returns entry, then pointer advances
// - font write low byte stores, then advances
// - font write high byte loads pointer
// - pointer increments inside valid span
// - last location wraps pointer to first
// - pointer above span forced to first
// - five locations per user character
// - scan limit selects two or four digits
// - digits driven in pairs per slot
// - one scan bit: pair zero or both
// - four modulators, nibble per digit
// - on time one to fifteen sixteenths
// - no-op register writes ignored
// - blink derived from oscillator ticks
// - scan period 5600 oscillator ticks with both pairs, 2800 with pair zero only
// - font memory 120 entries, 7 bits
// - font pointer never read back
`timescale 1ns/1ps
`default_nettype none
module lmfbi_ctrl
    import lmfbi_pkg::*;
#(
    parameter int FAST_HALF = LMFBI_FAST_HALF,  // fast blink half period
    parameter int SLOW_HALF = LMFBI_SLOW_HALF   // slow blink half period
)
(
    input  wire logic       core_clk_in,               // system clock
    input  wire logic       arst_n_in,                 // async reset, low
    input  wire logic       spi_sclk_in,               // serial clock pin
    input  wire logic       spi_cs_n_in,               // chip select, low
    input  wire logic       spi_din_in,                // serial data in
    input  wire logic       multiplex_clock_input_in,  // oscillator pin
    output logic            spi_dout_out,              // serial data out
    output logic            blink_out,                 // blink phase pin
    output logic [3:0]      digit_enable_out           // digit drives
);

    localparam int BW = $clog2(SLOW_HALF + 1);        // blink counter width
    localparam int SW = $clog2(LMFBI_STEP_TICKS + 1); // step tick width

    // pin synchronisers, stage one feeds stage two only
    logic [3:0] sync1_reg;          // first stage
    logic [3:0] sync2_reg;          // second stage
    logic       sclk_prev_reg;      // previous synced clock
    logic       cs_prev_reg;        // previous synced select
    logic       osc_prev_reg;       // previous synced oscillator

    logic       sclk_s;             // synced serial clock
    logic       cs_n_s;             // synced chip select
    logic       din_s;              // synced data
    logic       osc_s;              // synced oscillator

    // serial shifter state
    logic [4:0]  bit_cnt_reg;       // received bits, saturates
    logic [15:0] rx_reg;            // received frame
    logic [7:0]  tx_reg;            // outgoing read byte

    // register file
    logic [7:0] bright_lo_reg;      // digits 1 and 0 nibbles
    logic [7:0] bright_hi_reg;      // digits 3 and 2 nibbles
    logic       scan_limit_reg;     // pair select
    logic [7:0] config_reg;         // stored configuration bits
    logic [7:0] font_ptr_reg;       // font pointer, write only

    // font memory, no reset, contents undefined at power up
    logic [LMFBI_FONT_WIDTH-1:0] font_mem [LMFBI_FONT_DEPTH];

    // blink and scan timing
    logic [BW-1:0] blink_cnt_reg;   // ticks inside half period
    logic          plane_a_reg;     // true while plane a shows
    logic [SW-1:0] tick_cnt_reg;    // ticks inside one step
    logic [3:0]    step_reg;        // step inside slot
    logic          slot_reg;        // current digit pair
    logic [3:0]    pwm_on;          // modulator outputs

    // decoded events
    logic        sclk_rise;         // serial clock rising
    logic        sclk_fall;         // serial clock falling
    logic        cs_fall;           // frame start
    logic        cs_rise;           // frame end
    logic        osc_tick;          // oscillator rising edge
    logic        frame_done;        // complete frame released
    logic [7:0]  cmd_addr;          // frame address byte
    logic [7:0]  cmd_data;          // frame data byte
    logic        cmd_read;          // frame was a read
    logic        wr_en;             // frame was a write
    logic        font_data_op;      // font read or data write
    logic        font_ptr_load;     // font pointer write
    logic [7:0]  rd_addr;           // address as it completes
    logic [7:0]  rd_data;           // readback byte
    logic [6:0]  font_idx;          // memory index of pointer
    logic [BW-1:0] half_len;        // current half period

    assign sclk_s = sync2_reg[0];
    assign cs_n_s = sync2_reg[1];
    assign din_s  = sync2_reg[2];
    assign osc_s  = sync2_reg[3];

    // advance pointer, wrapping after last location
    function automatic logic [7:0] ptr_advance(input logic [7:0] p);
        if (p == LMFBI_PTR_LAST) begin
            ptr_advance = LMFBI_PTR_FIRST;
        end else begin
            ptr_advance = p + 8'h01;
        end
    endfunction : ptr_advance

    // pointer to memory index; five rows per character keep it linear
    function automatic logic [6:0] ptr_index(input logic [7:0] p);
        logic [7:0] d;
        d = p - LMFBI_PTR_FIRST;
        ptr_index = d[6:0];
    endfunction : ptr_index

    // two flip-flop synchronisers on every pin input
    always_ff @(posedge core_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            sync1_reg <= 4'h2;
            sync2_reg <= 4'h2;
        end else begin
            sync1_reg <= {multiplex_clock_input_in, spi_din_in,
                          spi_cs_n_in, spi_sclk_in};
            sync2_reg <= sync1_reg;
        end
    end

    // edge history taken from stage two only
    always_ff @(posedge core_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            sclk_prev_reg <= 1'b0;
            cs_prev_reg   <= 1'b1;
            osc_prev_reg  <= 1'b0;
        end else begin
            sclk_prev_reg <= sclk_s;
            cs_prev_reg   <= cs_n_s;
            osc_prev_reg  <= osc_s;
        end
    end

    assign sclk_rise = sclk_s && !sclk_prev_reg && !cs_n_s;
    assign sclk_fall = !sclk_s && sclk_prev_reg && !cs_n_s;
    assign cs_fall   = !cs_n_s && cs_prev_reg;
    assign cs_rise   = cs_n_s && !cs_prev_reg;
    assign osc_tick  = osc_s && !osc_prev_reg;

    // frames of the wrong length are dropped whole
    assign frame_done = cs_rise &&
                        (bit_cnt_reg == 5'(LMFBI_FRAME_BITS));
    assign cmd_addr   = rx_reg[15:8];
    assign cmd_data   = rx_reg[7:0];
    assign cmd_read   = cmd_addr[LMFBI_READ_BIT];
    assign wr_en      = frame_done && !cmd_read;
    assign font_idx   = ptr_index(font_ptr_reg);

    // font operations resolved from the released frame
    always_comb begin
        font_data_op  = 1'b0;
        font_ptr_load = 1'b0;
        if (frame_done) begin
            if (cmd_addr == LMFBI_ADDR_FONT_RD) begin
                font_data_op = 1'b1;
            end else if (cmd_addr == LMFBI_ADDR_FONT) begin
                font_ptr_load = cmd_data[LMFBI_PTR_MODE_BIT];
                font_data_op  = !cmd_data[LMFBI_PTR_MODE_BIT];
            end
        end
    end

    // bit counter and receive shifter, msb first
    always_ff @(posedge core_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            bit_cnt_reg <= 5'h00;
            rx_reg      <= 16'h0000;
        end else if (cs_fall) begin
            bit_cnt_reg <= 5'h00;
        end else if (sclk_rise) begin
            rx_reg <= {rx_reg[14:0], din_s};
            // saturate so overlong frames never match
            if (bit_cnt_reg <= 5'(LMFBI_FRAME_BITS)) begin
                bit_cnt_reg <= bit_cnt_reg + 5'h01;
            end
        end
    end

    assign rd_addr = {rx_reg[6:0], din_s};

    // readback mux for the address just completed
    always_comb begin
        rd_data = 8'h00;
        unique case ({1'b0, rd_addr[6:0]})
            LMFBI_ADDR_BRIGHT_LO: rd_data = bright_lo_reg;
            LMFBI_ADDR_BRIGHT_HI: rd_data = bright_hi_reg;
            LMFBI_ADDR_SCAN:      rd_data = {7'h00, scan_limit_reg};
            LMFBI_ADDR_CONFIG:    rd_data = {plane_a_reg,
                                             config_reg[6:0]};
            LMFBI_ADDR_FONT:      rd_data = {1'b0, font_mem[font_idx]};
            default:              rd_data = 8'h00;
        endcase
    end

    // transmit: load after the address byte, shift on falling edges
    always_ff @(posedge core_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            tx_reg       <= 8'h00;
            spi_dout_out <= 1'b0;
        end else if (cs_n_s) begin
            spi_dout_out <= 1'b0;
        end else if (sclk_rise &&
                     bit_cnt_reg == 5'(LMFBI_ADDR_BITS - 1)) begin
            // only reads answer; writes shift out zeros
            tx_reg <= rx_reg[6] ? rd_data : 8'h00;
        end else if (sclk_fall &&
                     bit_cnt_reg >= 5'(LMFBI_ADDR_BITS)) begin
            spi_dout_out <= tx_reg[7];
            tx_reg       <= {tx_reg[6:0], 1'b0};
        end
    end

    // plain registers, updated at frame release
    always_ff @(posedge core_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            bright_lo_reg  <= LMFBI_RST_BRIGHT;
            bright_hi_reg  <= LMFBI_RST_BRIGHT;
            scan_limit_reg <= LMFBI_RST_SCAN;
            config_reg     <= LMFBI_RST_CONFIG;
        end else if (wr_en) begin
            unique case (cmd_addr)
                LMFBI_ADDR_BRIGHT_LO: bright_lo_reg <= cmd_data;
                LMFBI_ADDR_BRIGHT_HI: bright_hi_reg <= cmd_data;
                LMFBI_ADDR_SCAN:
                    scan_limit_reg <= cmd_data[LMFBI_SCAN_BIT];
                LMFBI_ADDR_CONFIG:    config_reg    <= cmd_data;
                default: ;
            endcase
        end
    end

    // font pointer update at chip select release
    always_ff @(posedge core_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            font_ptr_reg <= LMFBI_RST_PTR;
        end else if (font_ptr_load) begin
            if (cmd_data > LMFBI_PTR_LAST) begin
                font_ptr_reg <= LMFBI_PTR_FIRST;
            end else begin
                font_ptr_reg <= cmd_data;
            end
        end else if (font_data_op) begin
            font_ptr_reg <= ptr_advance(font_ptr_reg);
        end
    end

    // font memory write, 7 bits per entry
    always_ff @(posedge core_clk_in) begin
        if (font_data_op && !cmd_read) begin
            font_mem[font_idx] <= cmd_data[LMFBI_FONT_WIDTH-1:0];
        end
    end

    assign half_len = config_reg[LMFBI_CFG_FAST_BIT] ?
                      BW'(FAST_HALF) : BW'(SLOW_HALF);

    // blink phase counter on oscillator ticks
    always_ff @(posedge core_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            blink_cnt_reg <= '0;
            plane_a_reg   <= 1'b1;
        end else if (wr_en && cmd_addr == LMFBI_ADDR_CONFIG &&
                     cmd_data[LMFBI_CFG_TSYNC_BIT]) begin
            // sync request restarts in plane a
            blink_cnt_reg <= '0;
            plane_a_reg   <= 1'b1;
        end else if (osc_tick) begin
            if (blink_cnt_reg >= half_len - BW'(1)) begin
                blink_cnt_reg <= '0;
                plane_a_reg   <= !plane_a_reg;
            end else begin
                blink_cnt_reg <= blink_cnt_reg + BW'(1);
            end
        end
    end

    // blink pin follows plane
    always_ff @(posedge core_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            blink_out <= 1'b1;
        end else begin
            blink_out <= plane_a_reg;
        end
    end

    // scan timebase: ticks, sixteen steps, two slots
    always_ff @(posedge core_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            tick_cnt_reg <= '0;
            step_reg     <= 4'h0;
            slot_reg     <= 1'b0;
        end else if (osc_tick) begin
            if (tick_cnt_reg == SW'(LMFBI_STEP_TICKS - 1)) begin
                tick_cnt_reg <= '0;
                step_reg     <= step_reg + 4'h1;
                if (step_reg == 4'hF) begin
                    slot_reg <= scan_limit_reg ? !slot_reg : 1'b0;
                end
            end else begin
                tick_cnt_reg <= tick_cnt_reg + SW'(1);
            end
        end
    end

    genvar g;
    generate
        for (g = 0; g < 4; g++) begin : g_digit
            lmfbi_pwm u_pwm (
                .core_clk_in   (core_clk_in),
                .arst_n_in     (arst_n_in),
                .level_in      (g < 2 ?
                                bright_lo_reg[4*(g%2) +: 4] :
                                bright_hi_reg[4*(g%2) +: 4]),
                .step_in       (step_reg),
                .slot_match_in (slot_reg == 1'(g / 2)),
                .on_out        (pwm_on[g])
            );
        end
    endgenerate

    // digit drives re-timed to the pins
    always_ff @(posedge core_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            digit_enable_out <= 4'h0;
        end else begin
            digit_enable_out <= pwm_on;
        end
    end

endmodule : lmfbi_ctrl
`default_nettype wire

// >>> core/lmfbi_pkg.sv
// shared constants for the led matrix font, blink and intensity control
package lmfbi_pkg;

    // register address codes, read flag in the top address bit
    localparam logic [7:0] LMFBI_ADDR_NOOP      = 8'h00;
    localparam logic [7:0] LMFBI_ADDR_BRIGHT_LO = 8'h01;
    localparam logic [7:0] LMFBI_ADDR_BRIGHT_HI = 8'h02;
    localparam logic [7:0] LMFBI_ADDR_SCAN      = 8'h03;
    localparam logic [7:0] LMFBI_ADDR_CONFIG    = 8'h04;
    localparam logic [7:0] LMFBI_ADDR_FONT      = 8'h05;
    localparam logic [7:0] LMFBI_ADDR_FONT_RD   = 8'h85;
    localparam int         LMFBI_READ_BIT       = 7;

    // font pointer span and character layout
    localparam logic [7:0] LMFBI_PTR_FIRST      = 8'h80;
    localparam logic [7:0] LMFBI_PTR_LAST       = 8'hF7;
    localparam logic [7:0] LMFBI_CHAR_LAST_BASE = 8'hF3;
    localparam int         LMFBI_FONT_DEPTH     = 120;
    localparam int         LMFBI_FONT_WIDTH     = 7;
    localparam int         LMFBI_CHAR_ROWS      = 5;
    localparam int         LMFBI_PTR_MODE_BIT   = 7;

    // configuration and scan register fields
    localparam int         LMFBI_CFG_PHASE_BIT  = 7;
    localparam int         LMFBI_CFG_TSYNC_BIT  = 4;
    localparam int         LMFBI_CFG_FAST_BIT   = 2;
    localparam int         LMFBI_SCAN_BIT       = 0;

    // reset values
    localparam logic [7:0] LMFBI_RST_BRIGHT     = 8'h00;
    localparam logic [7:0] LMFBI_RST_CONFIG     = 8'h00;
    localparam logic       LMFBI_RST_SCAN       = 1'b0;
    localparam logic [7:0] LMFBI_RST_PTR        = 8'h80;

    // serial frame: address byte then data byte
    localparam int         LMFBI_FRAME_BITS     = 16;
    localparam int         LMFBI_ADDR_BITS      = 8;

    // timing in oscillator ticks
    localparam int         LMFBI_OSC_REF_HZ     = 4_000_000;
    localparam int         LMFBI_BLINK_FAST_HZ  = 1;
    localparam int         LMFBI_BLINK_SLOW_DIV = 2;
    localparam int         LMFBI_FAST_HALF      =
        LMFBI_OSC_REF_HZ / (2 * LMFBI_BLINK_FAST_HZ);
    localparam int         LMFBI_SLOW_HALF      =
        LMFBI_FAST_HALF * LMFBI_BLINK_SLOW_DIV;
    localparam int         LMFBI_SCAN_DIV       = 5600;
    localparam int         LMFBI_SCAN_SLOTS     = 2;
    localparam int         LMFBI_PWM_STEPS      = 16;
    localparam int         LMFBI_STEP_TICKS     =
        LMFBI_SCAN_DIV / (LMFBI_SCAN_SLOTS * LMFBI_PWM_STEPS);
    localparam logic [3:0] LMFBI_PWM_MAX_ON     = 4'hF;

endpackage : lmfbi_pkg

// >>> core/lmfbi_pwm.sv
// one digit brightness modulator over sixteen slot steps
`timescale 1ns/1ps
`default_nettype none
module lmfbi_pwm
    import lmfbi_pkg::*;
(
    input  wire logic       core_clk_in,    // system clock
    input  wire logic       arst_n_in,      // async reset, low
    input  wire logic [3:0] level_in,       // brightness nibble
    input  wire logic [3:0] step_in,        // step inside slot
    input  wire logic       slot_match_in,  // this digit's slot
    output logic            on_out          // digit drive, registered
);

    logic [3:0] on_steps;   // steps the digit is lit

    always_comb begin
        if (level_in == LMFBI_PWM_MAX_ON) begin
            // top code saturates, keeps interdigit blanking
            on_steps = LMFBI_PWM_MAX_ON;
        end else begin
            on_steps = level_in + 4'h1;
        end
    end

    // lit during the first on_steps steps of its slot
    always_ff @(posedge core_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            on_out <= 1'b0;
        end else begin
            on_out <= slot_match_in && (step_in < on_steps);
        end
    end

endmodule : lmfbi_pwm
`default_nettype wire

// >>> bench/lmfbi_ctrl_sva.sv
// port checks for the led matrix control block
`timescale 1ns/1ps
`default_nettype none
module lmfbi_ctrl_sva
    import lmfbi_pkg::*;
#(
    parameter int FAST_HALF = LMFBI_FAST_HALF,  // fast blink half period
    parameter int SLOW_HALF = LMFBI_SLOW_HALF   // slow blink half period
)
(
    input wire logic       core_clk_in,
    input wire logic       arst_n_in,
    input wire logic       spi_sclk_in,
    input wire logic       spi_cs_n_in,
    input wire logic       spi_din_in,
    input wire logic       multiplex_clock_input_in,
    input wire logic       spi_dout_out,
    input wire logic       blink_out,
    input wire logic [3:0] digit_enable_out
);
    // longest lit run: fifteen steps, one edge of slack
    localparam int RUN_MAX = 15 * LMFBI_STEP_TICKS + 1;
    logic [2:0]  pin_d;      // osc, sclk, cs one clock back
    logic [3:0]  since_osc;  // clocks since osc rise
    logic [3:0]  since_fall; // clocks since sclk fall
    logic [3:0]  since_cs;   // clocks since any cs edge
    logic [15:0] run_ticks;  // osc rises while digit 0 lit
    default clocking cb @(posedge core_clk_in); endclocking
    default disable iff (!arst_n_in);
    // event age counters, saturating so they never wrap
    always_ff @(posedge core_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            pin_d      <= 3'b001;
            since_osc  <= 4'hF;
            since_fall <= 4'hF;
            since_cs   <= 4'hF;
            run_ticks  <= 16'h0000;
        end else begin
            pin_d <= {multiplex_clock_input_in, spi_sclk_in, spi_cs_n_in};
            since_osc <= (multiplex_clock_input_in && !pin_d[2]) ? 4'h0 :
                (since_osc == 4'hF) ? since_osc : since_osc + 4'h1;
            since_fall <= (!spi_sclk_in && pin_d[1]) ? 4'h0 :
                (since_fall == 4'hF) ? since_fall : since_fall + 4'h1;
            since_cs <= (spi_cs_n_in != pin_d[0]) ? 4'h0 :
                (since_cs == 4'hF) ? since_cs : since_cs + 4'h1;
            run_ticks <= !digit_enable_out[0] ? 16'h0000 :
                (multiplex_clock_input_in && !pin_d[2]) ?
                run_ticks + 16'h0001 : run_ticks;
        end
    end
    a_dout_idle_low:
        assert property (spi_cs_n_in [*6] |-> !spi_dout_out)
        else $error("dout not low while deselected");
    a_dout_after_fall:
        assert property ($changed(spi_dout_out) |->
            (since_fall < 4'h8 || since_cs < 4'h8))
        else $error("dout moved without an sclk fall");
    a_pairs_exclusive:
        assert property (|digit_enable_out[1:0] |-> !(|digit_enable_out[3:2]))
        else $error("both digit pairs lit together");
    // sync, tick decode and output flop put the change three clocks late
    a_blink_has_cause:
        assert property ($changed(blink_out) |->
            (since_osc inside {[4'h2:4'h4]} ||
             since_cs inside {[4'h2:4'h4]}))
        else $error("blink moved without tick or restart");
    a_blink_holds_steady:
        assert property ($changed(blink_out) |=> $stable(blink_out) [*8])
        else $error("blink phase too short");
    a_digit_min_on:
        assert property ($rose(digit_enable_out[0]) |=>
            digit_enable_out[0] [*8])
        else $error("digit lit for less than a step");
    a_digit_run_bound:
        assert property (int'(run_ticks) <= RUN_MAX)
        else $error("digit lit beyond fifteen steps");
    // one more flop than blink: modulator stage; reset release exempt
    a_digit_on_tick:
        assert property ($changed(digit_enable_out) |->
            (!$past(arst_n_in, 3) ||
             since_osc inside {[4'h3:4'h5]} ||
             since_cs inside {[4'h3:4'h5]}))
        else $error("digit moved without an osc tick");
    c_high_pair: cover property ($rose(digit_enable_out[2]));
    c_blink_fall: cover property ($fell(blink_out));
    c_dout_high: cover property ($rose(spi_dout_out));
endmodule : lmfbi_ctrl_sva
bind lmfbi_ctrl lmfbi_ctrl_sva #(
    .FAST_HALF(FAST_HALF),
    .SLOW_HALF(SLOW_HALF)
) u_sva (
    .core_clk_in, .arst_n_in, .spi_sclk_in, .spi_cs_n_in, .spi_din_in,
    .multiplex_clock_input_in, .spi_dout_out, .blink_out, .digit_enable_out
);
`default_nettype wire

// >>> bench/lmfbi_host.sv
// host serial master model driving the control block
`timescale 1ns/1ps
`default_nettype none
module lmfbi_host
    import lmfbi_pkg::*;
(
    input  wire logic core_clk_in,  // system clock
    input  wire logic spi_dout_in,  // read data from device
    output logic      spi_sclk_out, // serial clock, still between frames
    output logic      spi_cs_n_out, // chip select, low
    output logic      spi_din_out   // serial data to device
);
    // eight clocks per phase, well above the sync limit
    localparam int HALF = 8;
    initial begin
        spi_sclk_out = 1'b0;
        spi_cs_n_out = 1'b1;
        spi_din_out  = 1'b0;
    end
    // one frame msb first; read byte taken at rises 8 to 15
    task automatic xfer(input logic [15:0] frame, input int nbits,
                        output logic [7:0] rd);
        rd = 8'h00;
        spi_cs_n_out <= 1'b0;
        repeat (HALF) @(posedge core_clk_in);
        for (int i = 0; i < nbits; i++) begin
            spi_din_out <= frame[15-i];
            repeat (HALF) @(posedge core_clk_in);
            spi_sclk_out <= 1'b1;
            if (i >= LMFBI_ADDR_BITS) rd = {rd[6:0], spi_dout_in};
            repeat (HALF) @(posedge core_clk_in);
            spi_sclk_out <= 1'b0;
        end
        repeat (HALF) @(posedge core_clk_in);
        spi_cs_n_out <= 1'b1;
        // released line shows the inverse, never a stale bit
        spi_din_out  <= ~spi_din_out;
        repeat (HALF) @(posedge core_clk_in);
    endtask : xfer
endmodule : lmfbi_host
`default_nettype wire

// >>> bench/tb_lmfbi_ctrl.sv
// register, font, blink and scan tests for the control block
`timescale 1ns/1ps
`default_nettype none
module tb_lmfbi_ctrl
    import lmfbi_pkg::*;
;
    // short blink halves keep the run brief
    localparam int FH = 100;
    localparam int SH = 200;
    localparam logic [7:0] FNT = LMFBI_ADDR_FONT;
    logic        clk, arst_n, sclk, cs_n, din, dout, blink, hi_seen;
    logic [3:0]  dig;       // digit drives
    logic [2:0]  osc_cnt;   // osc at clk/8, faster than spec to save time
    logic [31:0] osc_ticks; // osc rises seen so far
    logic [31:0] t;         // tick mark
    logic [7:0]  v;         // last read byte
    logic [4:0]  sigs;      // watched outputs
    int          err_total;
    int          cmp_count;
    assign sigs = {blink, dig};
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    // oscillator divider and tick count
    always @(posedge clk) begin
        osc_cnt <= osc_cnt + 3'd1;
        if (osc_cnt == 3'd3) osc_ticks <= osc_ticks + 32'd1;
        hi_seen <= hi_seen | (|dig[3:2]);
    end
    lmfbi_ctrl #(.FAST_HALF(FH), .SLOW_HALF(SH)) dut (
        .core_clk_in              (clk),
        .arst_n_in                (arst_n),
        .spi_sclk_in              (sclk),
        .spi_cs_n_in              (cs_n),
        .spi_din_in               (din),
        .multiplex_clock_input_in (osc_cnt[2]),
        .spi_dout_out             (dout),
        .blink_out                (blink),
        .digit_enable_out         (dig)
    );
    lmfbi_host host (
        .core_clk_in  (clk),
        .spi_dout_in  (dout),
        .spi_sclk_out (sclk),
        .spi_cs_n_out (cs_n),
        .spi_din_out  (din)
    );
    task automatic give_verdict;
        $display("comparisons %0d mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : give_verdict
    task automatic check(input string what, input logic [31:0] seen,
                         input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            err_total++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        host.xfer({a, d}, 16, v);
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        host.xfer({a | 8'h80, 8'h00}, 16, v);
        check($sformatf("reg %h", a), {24'h0, v}, {24'h0, exp});
    endtask : rd
    // bounded wait for one output to reach a level
    task automatic wait_sig(input int idx, input logic lvl, input int lim);
        int n;
        n = 0;
        while (sigs[idx] !== lvl && n < lim) begin
            @(posedge clk);
            n++;
        end
        if (n >= lim) begin
            err_total++;
            $display("wrong value wait %0d expected %b seen timeout", idx, lvl);
            give_verdict();
        end
    endtask : wait_sig
    function automatic logic near(input logic [31:0] d, input int e);
        return (int'(d) >= e - 2) && (int'(d) <= e + 2);
    endfunction : near
    initial begin
        arst_n = 1'b0;
        osc_cnt = 3'd0;
        osc_ticks = 32'd0;
        hi_seen = 1'b0;
        err_total = 0;
        cmp_count = 0;
        repeat (6) @(posedge clk);
        arst_n <= 1'b1;
        repeat (2) @(posedge clk);
        check("blink reset", blink, 1'b1);
        wr(LMFBI_ADDR_BRIGHT_LO, 8'h0F);
        wr(LMFBI_ADDR_BRIGHT_HI, 8'hC3);
        rd(LMFBI_ADDR_BRIGHT_LO, 8'h0F);
        rd(LMFBI_ADDR_BRIGHT_HI, 8'hC3);
        wr(LMFBI_ADDR_NOOP, 8'hFF);
        rd(LMFBI_ADDR_BRIGHT_LO, 8'h0F);
        rd(LMFBI_ADDR_SCAN, 8'h00);
        // fill across the wrap: 0xF6, 0xF7, then 0x80
        wr(FNT, 8'hF6);
        wr(FNT, 8'h11);
        wr(FNT, 8'h22);
        wr(FNT, 8'h33);
        wr(FNT, 8'hF6);
        host.xfer({FNT, 8'h80}, 12, v);
        rd(FNT, 8'h11);
        rd(FNT, 8'h22);
        rd(FNT, 8'h33);
        wr(FNT, 8'hFA);
        rd(FNT, 8'h33);
        wr(FNT, LMFBI_CHAR_LAST_BASE);
        wr(FNT, 8'h7F);
        wr(FNT, 8'h80 + 8'd115);
        rd(FNT, 8'h7F);
        // phase readback just after each edge
        wait_sig(4, 1'b1, 4000);
        wait_sig(4, 1'b0, 4000);
        host.xfer({LMFBI_ADDR_CONFIG | 8'h80, 8'h00}, 16, v);
        check("phase b", v[7], 1'b0);
        wait_sig(4, 1'b1, 4000);
        t = osc_ticks;
        host.xfer({LMFBI_ADDR_CONFIG | 8'h80, 8'h00}, 16, v);
        check("phase a", v[7], 1'b1);
        wait_sig(4, 1'b0, 4000);
        check("slow half", near(osc_ticks - t, SH), 1'b1);
        wr(LMFBI_ADDR_CONFIG, 8'h14);
        check("restart", blink, 1'b1);
        wait_sig(4, 1'b0, 2000);
        t = osc_ticks;
        wait_sig(4, 1'b1, 2000);
        check("fast half", near(osc_ticks - t, FH), 1'b1);
        // pair zero only: digit 0 at 15/16, digit 1 at 1/16
        wait_sig(0, 1'b0, 25000);
        wait_sig(0, 1'b1, 25000);
        t = osc_ticks;
        wait_sig(1, 1'b0, 3000);
        check("dig1", near(osc_ticks - t, LMFBI_STEP_TICKS), 1'b1);
        wait_sig(0, 1'b0, 25000);
        check("dig0", near(osc_ticks - t, 15 * LMFBI_STEP_TICKS),
              1'b1);
        check("pair one idle", hi_seen, 1'b0);
        // no shutdown in this block; display carries only test data
        wr(LMFBI_ADDR_SCAN, 8'h01);
        rd(LMFBI_ADDR_SCAN, 8'h01);
        wait_sig(2, 1'b1, 30000);
        t = osc_ticks;
        wait_sig(2, 1'b0, 8000);
        check("dig2", near(osc_ticks - t, 4 * LMFBI_STEP_TICKS),
              1'b1);
        // digit 3 at thirteen steps still lit when digit 2 goes dark
        check("dig3", dig[3], 1'b1);
        give_verdict();
    end
endmodule : tb_lmfbi_ctrl
`default_nettype wire
